// ===== verilog/lcdgd_pkg.sv
package lcdgd_pkg;
	// Command opcodes
	localparam logic [7:0] CMD_COPY   = 8'h8A;
	localparam logic [7:0] CMD_DIM    = 8'h8C;
	localparam logic [7:0] CMD_CLEAR  = 8'h8E;
	localparam logic [7:0] CMD_BIAS   = 8'hFB;
	localparam logic [7:0] CMD_FRAME  = 8'hF2;
	localparam logic [7:0] CMD_GREY   = 8'hF7;
	localparam logic [7:0] CMD_OTPSET = 8'hF6;
	localparam logic [7:0] CMD_OTPPRG = 8'hF8;
	localparam logic [7:0] CMD_CONTR  = 8'h81;
	localparam logic [7:0] CMD_DUTY   = 8'hCA;
	localparam logic [7:0] CMD_COLADR = 8'h15;
	localparam logic [7:0] CMD_PAGADR = 8'h75;
	localparam logic [7:0] CMD_WRITE  = 8'h5C;
	localparam logic [7:0] CMD_POWER  = 8'h20;
	localparam logic [7:0] CMD_DISPON = 8'hAF;
	localparam logic [7:0] CMD_DISPOF = 8'hAE;
	localparam logic [7:0] CMD_SLPIN  = 8'h95;
	localparam logic [7:0] CMD_SLPOUT = 8'h94;
	localparam logic [7:0] CMD_NORMAL = 8'hA6;
	localparam logic [7:0] CMD_INVERS = 8'hA7;
	localparam logic [7:0] CMD_PARTON = 8'hA8;
	localparam logic [7:0] CMD_PARTOF = 8'hA9;
	localparam logic [7:0] CMD_NONE   = 8'h00;
	// Parameter counts and field values
	localparam logic [2:0] IDX_LAST_RECT = 3'h3;
	localparam logic [2:0] IDX_LAST_COPY = 3'h5;
	localparam logic [2:0] IDX_MAX       = 3'h7;
	localparam logic [3:0] BIAS_MAX      = 4'h6;
	localparam logic [3:0] BIAS_RST      = 4'h0;
	localparam logic [3:0] FRAME_78HZ    = 4'h0;
	localparam logic [3:0] INV_RST       = 4'h6;
	localparam logic [1:0] GREY_RST      = 2'h0;
	localparam logic [3:0] OTP_HDR       = 4'h1;
	localparam logic [3:0] OTP_TAIL      = 4'hA;
	localparam logic [1:0] OTP_ZERO      = 2'h0;
	localparam logic [15:0] DIM_MASK     = 16'h8410;
	localparam logic [15:0] PIX_ZERO     = 16'h0000;
	localparam logic [6:0] COL_END_RST   = 7'h67;
	localparam logic [6:0] ROW_END_RST   = 7'h4F;
	localparam logic [7:0] MUX_RST       = 8'h50;
	localparam logic [7:0] PWR_RST       = 8'h00;
	localparam logic [5:0] CONTR_RST     = 6'h20;
	localparam logic [2:0] GAIN_RST      = 3'h0;
	localparam int FIFO_DEPTH            = 32;
	localparam int FIFO_W                = 9;

	// Drive scheme settings held for the panel drive logic
	typedef struct packed {
		logic [3:0] bias;
		logic [3:0] frame;
		logic [3:0] inv;
		logic [1:0] grey;
	} lcdgd_drv_t;

	// Contrast level and regulator gain
	typedef struct packed {
		logic [5:0] level;
		logic [2:0] gain;
	} lcdgd_contr_t;

	// One host byte with its data/command flag
	typedef struct packed {
		logic       dc;
		logic [7:0] byte_val;
	} lcdgd_hbyte_t;
endpackage : lcdgd_pkg

// ===== verilog/lcdgd_fifo.sv
`timescale 1ns/1ps
module lcdgd_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 32
) (
	input  wire logic         sys_clk,  // System clock
	input  wire logic         rst_n,    // Async reset, low
	input  wire logic         ce,       // Clock enable
	input  wire logic         wr_valid, // Write offered
	output logic              wr_ready, // Room for a word
	input  wire logic [W-1:0] wr_data,  // Write word
	output logic              rd_valid, // Word available
	input  wire logic         rd_ready, // Reader takes word
	output logic [W-1:0]      rd_data   // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0]   count;
	logic [AW:0]   next_count;
	logic [AW-1:0] next_rptr;
	logic          head_hit;
	wire           do_wr = wr_valid & wr_ready & ce;
	wire           do_rd = rd_valid & rd_ready & ce;

	// Occupancy after this cycle's push and pop
	assign next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
	// Head word is a flop; a push into the next head slot bypasses
	// storage, since that slot is only written at this same edge
	assign next_rptr  = do_rd ? AW'(rptr + 1'b1) : rptr;
	assign head_hit   = do_wr & (wptr == next_rptr);

	// Pointers and registered flags; ready is early so it is a flop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr     <= '0;
			rptr     <= '0;
			count    <= '0;
			wr_ready <= 1'b1;
			rd_valid <= 1'b0;
			rd_data  <= '0;
		end else if (ce) begin
			if (do_wr) wptr <= AW'(wptr + 1'b1);
			rptr     <= next_rptr;
			rd_data  <= head_hit ? wr_data : mem[next_rptr];
			count    <= next_count;
			wr_ready <= next_count != (AW+1)'(DEPTH);
			rd_valid <= next_count != '0;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge sys_clk) begin
		if (do_wr) mem[wptr] <= wr_data;
	end
endmodule : lcdgd_fifo

// ===== verilog/lcdgd_decoder.sv
`timescale 1ns/1ps
module lcdgd_decoder (
	input  wire logic                  sys_clk,     // 50 MHz clock
	input  wire logic                  rst_n,       // Async reset, low
	input  wire logic                  ce,          // Clock enable
	input  wire logic                  host_valid,  // Host byte offered
	input  wire logic                  host_dc,     // 1 data, 0 command
	input  wire logic [7:0]            host_byte,   // Host byte
	output logic                       host_ready,  // FIFO has room
	input  wire logic [1:0]            scroll_mode, // Area scroll mode
	input  wire logic                  col_dir,     // Column scan dir
	input  wire logic                  page_dir,    // Page scan dir
	output logic                       busy,        // Window op running
	output logic [7:0]                 status_byte, // Status read value
	output lcdgd_pkg::lcdgd_drv_t      drv,         // Drive scheme
	output lcdgd_pkg::lcdgd_contr_t    contr,       // Contrast setting
	output logic [7:0]                 mux_rows,    // Scanned rows
	output logic [7:0]                 pwr_cfg,     // Power control
	output logic [4:0]                 otp_bits,    // Programmed offset
	output logic                       ram_re,      // RAM read strobe
	output logic                       ram_we,      // RAM write strobe
	output logic [13:0]                ram_addr,    // {row, col}
	output logic [15:0]                ram_wdata,   // RAM write pixel
	input  wire logic [15:0]           ram_rdata    // Read pixel, +1 cycle
);
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_ISSUE = 5'b00010,
		S_WAIT  = 5'b00100,
		S_CAP   = 5'b01000,
		S_WRITE = 5'b10000
	} lcdgd_state_t;

	lcdgd_state_t           state;
	lcdgd_pkg::lcdgd_hbyte_t fin;
	lcdgd_pkg::lcdgd_hbyte_t fout;
	logic                   f_valid;
	logic [7:0]             cmd;
	logic [2:0]             idx;
	logic [6:0]             crd [6];
	logic [6:0]             cx;
	logic [6:0]             cy;
	logic [6:0]             col_s;
	logic [6:0]             col_e;
	logic [6:0]             row_s;
	logic [6:0]             row_e;
	logic [6:0]             wcol;
	logic [6:0]             wrow;
	logic [7:0]             hi_byte;
	logic [3:0]             otp_hi;
	logic                   otp_hdr_ok;
	logic [4:0]             otp_pend;
	logic                   disp_on;
	logic                   sleep_on;
	logic                   inverse;
	logic                   partial;

	// Input bytes queue up so the host is not stalled by short ops
	assign fin.dc       = host_dc;
	assign fin.byte_val = host_byte;

	wire       pop_ok   = (state == S_IDLE);

	lcdgd_fifo #(
		.W     (lcdgd_pkg::FIFO_W),
		.DEPTH (lcdgd_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.wr_valid (host_valid),
		.wr_ready (host_ready),
		.wr_data  (fin),
		.rd_valid (f_valid),
		.rd_ready (pop_ok),
		.rd_data  (fout)
	);

	// Decode of the popped byte
	wire       pop      = f_valid & pop_ok & ce;
	wire       is_data  = fout.dc;
	wire [7:0] fb       = fout.byte_val;
	wire       pop_cmd  = pop & ~is_data;
	wire       pop_dat  = pop & is_data;
	wire       is_copy  = (cmd == lcdgd_pkg::CMD_COPY);
	wire       is_dim   = (cmd == lcdgd_pkg::CMD_DIM);
	wire       is_clear = (cmd == lcdgd_pkg::CMD_CLEAR);
	wire       is_rect  = is_copy | is_dim | is_clear;
	wire [2:0] idx_last = is_copy ? lcdgd_pkg::IDX_LAST_COPY
	                              : lcdgd_pkg::IDX_LAST_RECT;
	wire       rect_go  = pop_dat & is_rect & (idx == idx_last);
	wire       otp_lo_ok = (fb[7:6] == lcdgd_pkg::OTP_ZERO)
	                     & (fb[3:0] == lcdgd_pkg::OTP_TAIL) & otp_hdr_ok;
	wire       wr_pix   = pop_dat & (cmd == lcdgd_pkg::CMD_WRITE) & idx[0];

	// Window walk: source pixel, destination and end test
	// copy offset
	wire [6:0] dst_x  = is_copy ? 7'(cx - crd[0] + crd[4]) : cx;
	wire [6:0] dst_y  = is_copy ? 7'(cy - crd[1] + crd[5]) : cy;
	wire       x_end  = (cx == crd[2]);
	wire       y_end  = (cy == crd[3]);
	wire       wc_end = (wcol == col_e);
	wire       wr_end = (wrow == row_e);

	// Command latch and parameter index
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd <= lcdgd_pkg::CMD_NONE;
			idx <= '0;
		end else if (pop_cmd) begin
			cmd <= fb;
			idx <= '0;
		// write index wraps so pixel bytes keep pairing
		end else if (pop_dat && (idx != lcdgd_pkg::IDX_MAX
		                         || cmd == lcdgd_pkg::CMD_WRITE)) begin
			idx <= 3'(idx + 1'b1);
		end
	end

	// Rectangle coordinates, fixed during the op
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			crd <= '{default: '0};
		end else if (pop_dat && is_rect && idx <= idx_last) begin
			crd[idx] <= fb[6:0];
		end
	end

	// Drive scheme settings
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drv.bias  <= lcdgd_pkg::BIAS_RST;
			drv.frame <= lcdgd_pkg::FRAME_78HZ;
			drv.inv   <= lcdgd_pkg::INV_RST;
			drv.grey  <= lcdgd_pkg::GREY_RST;
		end else if (pop_dat) begin
			if (cmd == lcdgd_pkg::CMD_BIAS && fb[3:0] <= lcdgd_pkg::BIAS_MAX)
				drv.bias <= fb[3:0];
			// frame rate, then inversion as second byte
			if (cmd == lcdgd_pkg::CMD_FRAME && idx == 3'h0)
				drv.frame <= fb[3:0];
			if (cmd == lcdgd_pkg::CMD_FRAME && idx == 3'h1)
				drv.inv <= fb[3:0];
			if (cmd == lcdgd_pkg::CMD_GREY)
				drv.grey <= fb[1:0];
		end
	end

	// Contrast, duty and power bytes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			contr.level <= lcdgd_pkg::CONTR_RST;
			contr.gain  <= lcdgd_pkg::GAIN_RST;
			mux_rows    <= lcdgd_pkg::MUX_RST;
			pwr_cfg     <= lcdgd_pkg::PWR_RST;
		end else if (pop_dat) begin
			if (cmd == lcdgd_pkg::CMD_CONTR && idx == 3'h0)
				contr.level <= fb[5:0];
			if (cmd == lcdgd_pkg::CMD_CONTR && idx == 3'h1)
				contr.gain <= fb[2:0];
			if (cmd == lcdgd_pkg::CMD_DUTY)
				mux_rows <= {6'(fb[5:0] + 1'b1), 2'b00};
			if (cmd == lcdgd_pkg::CMD_POWER)
				pwr_cfg <= fb;
		end
	end

	// Offset bytes; a malformed byte leaves the pending value alone
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			otp_hi     <= '0;
			otp_hdr_ok <= 1'b0;
			otp_pend   <= '0;
		end else if (pop_dat && cmd == lcdgd_pkg::CMD_OTPSET) begin
			if (idx == 3'h0) begin
				otp_hi     <= fb[3:0];
				otp_hdr_ok <= (fb[7:4] == lcdgd_pkg::OTP_HDR);
			end else if (idx == 3'h1 && otp_lo_ok) begin
				otp_pend <= {otp_hi, fb[5]};
			end
		end
	end

	// Fuses only ever gain ones; reset does not model reloading
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			otp_bits <= '0;
		end else if (pop_cmd && fb == lcdgd_pkg::CMD_OTPPRG) begin
			otp_bits <= otp_bits | otp_pend;
		end
	end

	// Display mode flags from plain commands
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			disp_on  <= 1'b0;
			sleep_on <= 1'b1;
			inverse  <= 1'b0;
			partial  <= 1'b0;
		end else if (pop_cmd) begin
			if (fb == lcdgd_pkg::CMD_DISPON) disp_on <= 1'b1;
			if (fb == lcdgd_pkg::CMD_DISPOF) disp_on <= 1'b0;
			if (fb == lcdgd_pkg::CMD_SLPIN)  sleep_on <= 1'b1;
			if (fb == lcdgd_pkg::CMD_SLPOUT) sleep_on <= 1'b0;
			if (fb == lcdgd_pkg::CMD_NORMAL) inverse <= 1'b0;
			if (fb == lcdgd_pkg::CMD_INVERS) inverse <= 1'b1;
			if (fb == lcdgd_pkg::CMD_PARTON) partial <= 1'b1;
			if (fb == lcdgd_pkg::CMD_PARTOF) partial <= 1'b0;
		end
	end

	// Status byte refreshed every enabled cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_byte <= '0;
		end else if (ce) begin
			status_byte <= {partial, inverse, sleep_on, disp_on,
			                page_dir, col_dir, scroll_mode};
		end
	end

	// Write window bounds and the write pointer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			col_s   <= '0;
			col_e   <= lcdgd_pkg::COL_END_RST;
			row_s   <= '0;
			row_e   <= lcdgd_pkg::ROW_END_RST;
			wcol    <= '0;
			wrow    <= '0;
			hi_byte <= '0;
		end else if (pop_cmd && fb == lcdgd_pkg::CMD_WRITE) begin
			wcol <= col_s;
			wrow <= row_s;
		end else if (pop_dat) begin
			if (cmd == lcdgd_pkg::CMD_COLADR && idx == 3'h0) col_s <= fb[6:0];
			if (cmd == lcdgd_pkg::CMD_COLADR && idx == 3'h1) col_e <= fb[6:0];
			if (cmd == lcdgd_pkg::CMD_PAGADR && idx == 3'h0) row_s <= fb[6:0];
			if (cmd == lcdgd_pkg::CMD_PAGADR && idx == 3'h1) row_e <= fb[6:0];
			if (cmd == lcdgd_pkg::CMD_WRITE && !idx[0]) hi_byte <= fb;
			if (wr_pix) begin
				wcol <= wc_end ? col_s : 7'(wcol + 1'b1);
				if (wc_end) wrow <= wr_end ? row_s : 7'(wrow + 1'b1);
			end
		end
	end

	// Window engine and RAM port; one pixel per pass, read before
	// write so an overlapping copy superimposes like the walk order
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= S_IDLE;
			busy      <= 1'b0;
			cx        <= '0;
			cy        <= '0;
			ram_re    <= 1'b0;
			ram_we    <= 1'b0;
			ram_addr  <= '0;
			ram_wdata <= '0;
		end else if (ce) begin
			unique case (state)
				S_IDLE: begin
					ram_we <= wr_pix;
					if (wr_pix) begin
						ram_addr  <= {wrow, wcol};
						ram_wdata <= {hi_byte, fb};
					end
					if (rect_go) begin
						busy  <= 1'b1;
						cx    <= crd[0];
						cy    <= crd[1];
						state <= S_ISSUE;
					end
				end
				S_ISSUE: begin
					if (is_clear) begin
						ram_we    <= 1'b1;
						ram_addr  <= {cy, cx};
						ram_wdata <= lcdgd_pkg::PIX_ZERO;
						state     <= S_WRITE;
					end else begin
						ram_re   <= 1'b1;
						ram_addr <= {cy, cx};
						state    <= S_WAIT;
					end
				end
				S_WAIT: begin
					ram_re <= 1'b0;
					state  <= S_CAP;
				end
				S_CAP: begin
					ram_we   <= 1'b1;
					ram_addr <= {dst_y, dst_x};
					ram_wdata <= is_dim ? (ram_rdata | lcdgd_pkg::DIM_MASK)
					                    : ram_rdata;
					state     <= S_WRITE;
				end
				S_WRITE: begin
					ram_we <= 1'b0;
					cx     <= x_end ? crd[0] : 7'(cx + 1'b1);
					if (x_end) cy <= 7'(cy + 1'b1);
					if (x_end && y_end) begin
						busy  <= 1'b0;
						state <= S_IDLE;
					end else begin
						state <= S_ISSUE;
					end
				end
				default: begin
					state <= S_IDLE;
					busy  <= 1'b0;
				end
			endcase
		end
	end

	// Clear never writes anything but zero
	AST_CLEAR_ZERO: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(ram_we && state == S_WRITE && is_clear) |-> ram_wdata == '0)
		else $error("clear wrote a nonzero pixel");

	// Dimmed pixel carries the mask and keeps the old bits
	AST_DIM_MASK: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(ce && state == S_CAP && is_dim)
		|=> ram_we && ram_wdata == ($past(ram_rdata) | lcdgd_pkg::DIM_MASK))
		else $error("dim result wrong");

	// Dimming a dimmed pixel writes it back unchanged
	AST_DIM_IDEM: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(ce && state == S_CAP && is_dim
		 && (ram_rdata & lcdgd_pkg::DIM_MASK) == lcdgd_pkg::DIM_MASK)
		|=> ram_wdata == $past(ram_rdata))
		else $error("dim changed a dimmed pixel");

	// Fuse bits never fall
	AST_OTP_ONCE: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(otp_bits & $past(otp_bits)) == $past(otp_bits))
		else $error("otp bit went back");

	// Nothing is taken from the queue while an op runs
	AST_BUSY_DEFER: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		busy |-> !pop && state != S_IDLE)
		else $error("byte taken while busy");

	// Contrast level follows its data byte
	AST_CONTR_LVL: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(pop_dat && cmd == lcdgd_pkg::CMD_CONTR && idx == 3'h0)
		|=> contr.level == $past(fb[5:0]))
		else $error("contrast level not stored");

	// Row count is four times the duty byte plus four
	AST_DUTY_ROWS: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(pop_dat && cmd == lcdgd_pkg::CMD_DUTY && fb < 8'h20)
		|=> mux_rows == 8'(({2'b00, $past(fb[5:0])} + 8'h01) * 8'h04))
		else $error("duty rows wrong");

	// Host writes land inside the window columns
	AST_WIN_WRITE: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_pix && col_s <= col_e && wcol >= col_s && wcol <= col_e)
		|=> ram_we && ram_addr[6:0] >= col_s && ram_addr[6:0] <= col_e)
		else $error("pixel write outside window");

	// Bias never leaves its range
	AST_BIAS_RANGE: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		drv.bias <= lcdgd_pkg::BIAS_MAX)
		else $error("bias out of range");

	// Bad second offset byte leaves pending value
	AST_OTP_FRAME: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(pop_dat && cmd == lcdgd_pkg::CMD_OTPSET && idx == 3'h1
		 && fb[3:0] != lcdgd_pkg::OTP_TAIL)
		|=> $stable(otp_pend))
		else $error("malformed offset accepted");
endmodule : lcdgd_decoder

// ===== verification/lcdgd_ram_model.sv
`timescale 1ns/1ps
module lcdgd_ram_model (
	input  wire logic        sys_clk,   // System clock
	input  wire logic        ram_re,    // Read strobe
	input  wire logic        ram_we,    // Write strobe
	input  wire logic [13:0] ram_addr,  // {row, col}
	input  wire logic [15:0] ram_wdata, // Write pixel
	output logic      [15:0] ram_rdata  // Read pixel
);
	logic [15:0] mem [0:16383];
	logic        hold;

	// Known fill so untouched pixels can be told apart
	initial begin
		for (int i = 0; i < 16384; i++) begin
			mem[i] = i[15:0] ^ 16'hA5C3;
		end
		ram_rdata = 16'h3C3C;
		hold = 1'b0;
	end

	// Read data holds two cycles, then scrambles every cycle
	always @(posedge sys_clk) begin
		if (ram_we) begin
			mem[ram_addr] <= ram_wdata;
		end
		if (ram_re) begin
			ram_rdata <= mem[ram_addr];
			hold <= 1'b1;
		end else if (hold) begin
			hold <= 1'b0;
		end else begin
			ram_rdata <= ~ram_rdata;
		end
	end
endmodule : lcdgd_ram_model

// ===== verification/tb_lcdgd_decoder.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
$display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module tb_lcdgd_decoder;
	logic                    sys_clk, rst_n, ce, host_valid, host_dc;
	logic [7:0]              host_byte, status_byte, mux_rows, pwr_cfg;
	logic                    host_ready, col_dir, page_dir, busy;
	logic [1:0]              scroll_mode;
	lcdgd_pkg::lcdgd_drv_t   drv;
	lcdgd_pkg::lcdgd_contr_t contr;
	logic [4:0]              otp_bits;
	logic                    ram_re, ram_we;
	logic [13:0]             ram_addr;
	logic [15:0]             ram_wdata, ram_rdata;
	logic [15:0]             pix [0:7];
	int                      err_total, checked, seed, k, n;
	logic [31:0]             r;
	logic [7:0]              last;
	logic [3:0]              eb;
	logic [7:0]              st_cmd [0:7];

	lcdgd_decoder u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.host_valid(host_valid), .host_dc(host_dc), .host_byte(host_byte),
		.host_ready(host_ready), .scroll_mode(scroll_mode),
		.col_dir(col_dir), .page_dir(page_dir), .busy(busy),
		.status_byte(status_byte), .drv(drv), .contr(contr),
		.mux_rows(mux_rows), .pwr_cfg(pwr_cfg), .otp_bits(otp_bits),
		.ram_re(ram_re), .ram_we(ram_we), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
	lcdgd_ram_model u_ram (.sys_clk(sys_clk), .ram_re(ram_re),
		.ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_rdata(ram_rdata));

	// Pixel address as the engine forms it
	function automatic logic [13:0] adr(input int c, input int rw);
		adr = {rw[6:0], c[6:0]};
	endfunction : adr

	task finish_test;
		if (err_total == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test

	task idle(input int c);
		repeat (c) @(negedge sys_clk);
	endtask : idle

	// Hold the byte until ready is seen at a taking edge
	task push(input logic dc, input logic [7:0] b);
		logic rdy;
		int   w;
		w = 0;
		host_dc = dc;
		host_byte = b;
		host_valid = 1'b1;
		rdy = host_ready;
		@(negedge sys_clk);
		while (rdy !== 1'b1 && w < 2000) begin
			rdy = host_ready;
			w++;
			@(negedge sys_clk);
		end
		host_valid = 1'b0;
		if (rdy !== 1'b1) begin
			err_total++;
			$display("ERROR %0t: host byte never taken", $time);
		end
		@(negedge sys_clk);
	endtask : push

	task coords(input int a, input int b, input int c, input int d);
		push(1'b1, a[7:0]);
		push(1'b1, b[7:0]);
		push(1'b1, c[7:0]);
		push(1'b1, d[7:0]);
	endtask : coords

	// Bounded wait for a window operation to finish
	task wait_op;
		n = 0;
		while (busy !== 1'b1 && n < 20) begin @(negedge sys_clk); n++; end
		`CHK(busy, 1'b1)
		while (busy !== 1'b0 && n < 5000) begin @(negedge sys_clk); n++; end
		`CHK(busy, 1'b0)
		idle(2);
	endtask : wait_op

	// Free-running clock, 20 ns period
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Watchdog well beyond the expected run
	initial begin
		#400000;
		err_total++;
		finish_test();
	end

	initial begin
		err_total = 0; checked = 0; seed = 12475;
		rst_n = 1'b0; ce = 1'b1; host_valid = 1'b0; host_dc = 1'b0;
		host_byte = 8'h00; scroll_mode = 2'h0; col_dir = 1'b0; page_dir = 1'b0;
		idle(10);
		`CHK(drv, {lcdgd_pkg::BIAS_RST, lcdgd_pkg::FRAME_78HZ, lcdgd_pkg::INV_RST, lcdgd_pkg::GREY_RST})
		`CHK(drv.inv, 4'h6)
		`CHK(contr, {lcdgd_pkg::CONTR_RST, lcdgd_pkg::GAIN_RST})
		`CHK({otp_bits, busy, host_ready}, 7'h01)
		rst_n = 1'b1;
		push(1'b0, 8'hD1);
		push(1'b0, lcdgd_pkg::CMD_SLPOUT);
		// Window writes, row major inside col 2..5 row 3..4
		push(1'b0, lcdgd_pkg::CMD_COLADR); push(1'b1, 8'h02); push(1'b1, 8'h05);
		push(1'b0, lcdgd_pkg::CMD_PAGADR); push(1'b1, 8'h03); push(1'b1, 8'h04);
		push(1'b0, lcdgd_pkg::CMD_WRITE);
		for (k = 0; k < 8; k++) begin
			r = $random(seed);
			pix[k] = (k == 0) ? 16'hFFFF : r[15:0];
			push(1'b1, pix[k][15:8]);
			push(1'b1, pix[k][7:0]);
		end
		idle(4);
		for (k = 0; k < 8; k++) `CHK(u_ram.mem[adr(2 + k % 4, 3 + k / 4)], pix[k])
		`CHK(u_ram.mem[adr(6, 3)], adr(6, 3) ^ 16'hA5C3)
		// Frozen clock enable: offered bytes are neither taken nor decoded
		ce = 1'b0;
		push(1'b0, lcdgd_pkg::CMD_POWER); push(1'b1, 8'h5A);
		`CHK(pwr_cfg, lcdgd_pkg::PWR_RST)
		ce = 1'b1;
		// Dim the window; wait_op reuses n, so the loop ends after one pass
		// windows keep start<=end inside the panel
		for (n = 0; n < 2; n++) begin
			push(1'b0, lcdgd_pkg::CMD_DIM); coords(2, 3, 5, 4); wait_op();
			for (k = 0; k < 8; k++) `CHK(u_ram.mem[adr(2 + k % 4, 3 + k / 4)], pix[k] | lcdgd_pkg::DIM_MASK)
		end
		// Copy a 2x2 block to col 10 row 20
		push(1'b0, lcdgd_pkg::CMD_COPY); coords(2, 3, 3, 4);
		push(1'b1, 8'h0A); push(1'b1, 8'h14); wait_op();
		for (k = 0; k < 4; k++) `CHK(u_ram.mem[adr(10 + k % 2, 20 + k / 2)], pix[(k / 2) * 4 + k % 2] | lcdgd_pkg::DIM_MASK)
		// Long clear; fill the buffer while the engine holds input off
		push(1'b0, lcdgd_pkg::CMD_CLEAR); coords(40, 40, 71, 55);
		n = 0;
		while (busy !== 1'b1 && n < 20) begin @(negedge sys_clk); n++; end
		eb = 4'h0; last = pwr_cfg; k = 0;
		while (host_ready === 1'b1 && k < 64) begin
			r = $random(seed);
			host_dc = k[0];
			host_byte = k[0] ? r[7:0] : lcdgd_pkg::CMD_POWER;
			if (k[0]) last = r[7:0];
			host_valid = 1'b1;
			@(negedge sys_clk);
			k++;
		end
		host_valid = 1'b0;
		`CHK(k, lcdgd_pkg::FIFO_DEPTH)
		`CHK(busy, 1'b1)
		wait_op(); idle(80);
		`CHK(pwr_cfg, last)
		for (k = 0; k < 512; k++) `CHK(u_ram.mem[adr(40 + k % 32, 40 + k / 32)], 16'h0000)
		`CHK(u_ram.mem[adr(72, 40)], adr(72, 40) ^ 16'hA5C3)
		// Drive settings, grey modes and count corners
		for (k = 0; k < 8; k++) begin
			r = $random(seed);
			if (k == 0) r[2:0] = 3'h7;
			if (k == 1) r = 32'h27FF_FFF6;
			// odd field: even count never divides odd mux plus icon
			r[12] = 1'b1;
			if (r[2:0] != 3'h7) eb = {1'b0, r[2:0]};
			push(1'b0, lcdgd_pkg::CMD_BIAS); push(1'b1, {5'h00, r[2:0]});
			push(1'b0, lcdgd_pkg::CMD_FRAME);
			push(1'b1, {4'h0, r[11:8]}); push(1'b1, {4'h0, r[15:12]});
			push(1'b0, lcdgd_pkg::CMD_GREY); push(1'b1, {6'h00, k[1:0]});
			push(1'b0, lcdgd_pkg::CMD_CONTR);
			push(1'b1, {2'h0, r[21:16]}); push(1'b1, {5'h00, r[24:22]});
			push(1'b0, lcdgd_pkg::CMD_DUTY); push(1'b1, {3'h0, r[29:25] % 20});
			push(1'b0, lcdgd_pkg::CMD_POWER); push(1'b1, r[31:24]);
			idle(6);
			`CHK(drv, {eb, r[11:8], r[15:12], k[1:0]})
			`CHK(contr, {r[21:16], r[24:22]})
			`CHK(mux_rows, 8'(((r[29:25] % 20) + 1) * 4))
			`CHK(pwr_cfg, r[31:24])
		end
		// Offset load and burn: good, bad tail, bad header, negative
		// offsets of +4 and -5 as contrast step differences
		st_cmd = '{8'h12, 8'h0A, 8'h1F, 8'h2B, 8'h3D, 8'h2A, 8'h1D, 8'h2A};
		for (k = 0; k < 4; k++) begin
			push(1'b0, lcdgd_pkg::CMD_OTPSET);
			push(1'b1, st_cmd[2 * k]); push(1'b1, st_cmd[2 * k + 1]);
			push(1'b0, lcdgd_pkg::CMD_OTPPRG); idle(6);
			`CHK(otp_bits, (k == 3) ? 5'h1F : 5'h04)
		end
		// Status follows mode commands and level inputs
		r = $random(seed);
		scroll_mode = r[1:0]; col_dir = r[2]; page_dir = r[3];
		st_cmd = '{8'hAF, 8'h95, 8'hA7, 8'hA8, 8'hAE, 8'h94, 8'hA6, 8'hA9};
		last = 8'h00;
		for (k = 0; k < 8; k++) begin
			push(1'b0, st_cmd[k]); idle(6);
			if (k == 0) last[4] = 1'b1;
			if (k == 4) last[4] = 1'b0;
			if (k == 1) last[5] = 1'b1;
			if (k == 5) last[5] = 1'b0;
			if (k == 2) last[6] = 1'b1;
			if (k == 6) last[6] = 1'b0;
			if (k == 3) last[7] = 1'b1;
			if (k == 7) last[7] = 1'b0;
			`CHK(status_byte, {last[7:4], page_dir, col_dir, scroll_mode})
		end
		finish_test();
	end
endmodule : tb_lcdgd_decoder
